// [logic/ism_consts.svh]
// constants and register map of the two-wire serial memory link
// Contract
// - STOP aborts any operation in progress
// - START aborts and readies for new command
// - data stable while clock high; sampled high
// - receiver pulls data low in ninth bit
// - undriven acknowledge aborts; device readdressable
// - master withholds acknowledge on last read
// - upper address nibble must match type code
// - address bits three..one select 256-byte page
// - address bit zero: one read, zero write
// - write: word byte forms low address
// - read: page latched, low bits kept
// - increment address latch before each acknowledge
// - top address wraps to zero
// - unlimited sequential bytes per operation
// - read: eight bits out, then sample acknowledge
// - write: eight bits in, then acknowledge
// - every byte travels most significant first
// - commit on eighth bit; earlier abort discards
// - no write recovery; poll always acknowledged
// - protect pin high: no ack, write, increment
// - protect pin low or open: writable (no pull-down in the device: only a low pin writes)
// - sample on rising, change on falling edge
// - random read: write address, repeated START, read
`ifndef ISM_CONSTS_SVH
`define ISM_CONSTS_SVH
`define ISM_ADDR_W 11
`define ISM_PAGE_LSB 1
`define ISM_TYPE_LSB 4
// arbitrary device type code
`define ISM_DEV_TYPE_DFLT 4'h5
`define ISM_MCLK_NS 10
`define ISM_SCL_PERIOD_NS 1000
`define ISM_QTR_CYC ((`ISM_SCL_PERIOD_NS + 4 * `ISM_MCLK_NS - 1) / (4 * `ISM_MCLK_NS))
`define ISM_QTR_MIN 16'h0002
`define ISM_OFS_CMD 5'h00
`define ISM_OFS_TX 5'h04
`define ISM_OFS_RX 5'h08
`define ISM_OFS_STAT 5'h0C
`define ISM_OFS_DIV 5'h10
`define ISM_CMD_ACK_BIT 2
`define ISM_STAT_BUSY_BIT 0
`define ISM_STAT_NAK_BIT 1
`define ISM_STAT_SDA_BIT 2
`endif

// [logic/ism_pkg.sv]
// types shared by both ends of the serial memory link
package ism_pkg;
   typedef enum {DEV_IDLE, DEV_ADDR, DEV_WORD, DEV_WR, DEV_RD} ism_dev_state_e;
   typedef enum {MS_IDLE, MS_START, MS_BYTE, MS_STOP} ism_mst_state_e;
   typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} ism_cmd_e;
   typedef logic [4:0] ism_addr_t;
   typedef logic [15:0] ism_word_t;
endpackage

// [logic/ism_if.sv]
// two-wire bus wiring with open-drain resolution and pull-ups
`timescale 1ns/1ps
interface ism_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;
   assign scl = m_scl_oe ? m_scl_o : 1'b1;
   assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);
   modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
      input scl, input sda);
   modport dev (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

// [logic/ism_dev.sv]
// serial memory slave: 2K byte array behind the two-wire bus
`timescale 1ns/1ps
`include "ism_consts.svh"
module ism_dev #(
   parameter int ADDR_W = `ISM_ADDR_W,
   parameter logic [3:0] DEV_TYPE = `ISM_DEV_TYPE_DFLT
) (
   input wire logic mclk,
   input wire logic resetn,
   ism_if.dev bus,
   input wire logic wp,
   output logic selected,
   output logic [ADDR_W-1:0] cur_addr,
   output logic wr_pulse,
   output logic [7:0] wr_data
);
   localparam int PG_W = ADDR_W - 8;
   localparam int DEPTH = 1 << ADDR_W;

   generate
      if (ADDR_W < 9 || ADDR_W > 11) begin : g_bad_width
         $error("ism_dev: ADDR_W must lie between 9 and 11");
      end
   endgenerate

   logic scl_m_q;
   logic scl_s_q;
   logic scl_p_q;
   logic sda_m_q;
   logic sda_s_q;
   logic sda_p_q;
   logic wp_m_q;
   logic wp_s_q;
   ism_pkg::ism_dev_state_e state_q;
   logic [3:0] cnt_q;
   logic ack_q;
   logic dir_rd_q;
   logic mack_q;
   logic [7:0] sh_q;
   logic [ADDR_W-1:0] addr_q;
   logic sda_oe_q;
   logic selected_q;
   logic wr_pulse_q;
   logic [7:0] wr_data_q;
   logic [7:0] mem [DEPTH];

   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   logic rx_state;
   logic byte_done;
   logic ack_enter;
   logic ack_leave;
   logic dev_hit;
   logic wr_commit;
   logic load_rd;
   logic tx_bit;
   logic [7:0] byte_in;
   logic [7:0] rd_byte;

   // pins cross into mclk through two flops; idle bus level at reset
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= bus.scl;
         scl_s_q <= scl_m_q;
         scl_p_q <= scl_s_q;
         sda_m_q <= bus.sda;
         sda_s_q <= sda_m_q;
         sda_p_q <= sda_s_q;
      end
   end

   // protect pin crosses through two flops; reads low only at reset, no pull-down
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wp_m_q <= 1'b0;
         wp_s_q <= 1'b0;
      end else begin
         wp_m_q <= wp;
         wp_s_q <= wp_m_q;
      end
   end

   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;
   // a data edge while the clock stays high is a bus condition
   assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_ev = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
   assign rx_state = (state_q == ism_pkg::DEV_ADDR) || (state_q == ism_pkg::DEV_WORD) ||
      (state_q == ism_pkg::DEV_WR);
   assign byte_in = {sh_q[6:0], sda_s_q};
   assign rd_byte = mem[addr_q];
   assign byte_done = scl_rise & ~ack_q & rx_state & (cnt_q == 4'h7);
   assign ack_enter = scl_fall & ~ack_q & (cnt_q == 4'h8) & (state_q != ism_pkg::DEV_IDLE);
   assign ack_leave = scl_fall & ack_q;
   assign dev_hit = sh_q[7:`ISM_TYPE_LSB] == DEV_TYPE;
   assign wr_commit = byte_done & (state_q == ism_pkg::DEV_WR) & ~wp_s_q;
   assign load_rd = ack_leave & (((state_q == ism_pkg::DEV_ADDR) & dir_rd_q) |
      ((state_q == ism_pkg::DEV_RD) & mack_q));
   assign tx_bit = scl_fall & ~ack_q & (state_q == ism_pkg::DEV_RD) & (cnt_q < 4'h8);

   // byte framing: state, bit count and acknowledge phase
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ism_pkg::DEV_IDLE;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (start_ev) begin
         state_q <= ism_pkg::DEV_ADDR;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (stop_ev) begin
         state_q <= ism_pkg::DEV_IDLE;
         cnt_q <= 4'h0;
         ack_q <= 1'b0;
      end else if (scl_rise & ~ack_q & rx_state) begin
         cnt_q <= cnt_q + 4'h1;
      end else if (tx_bit) begin
         cnt_q <= cnt_q + 4'h1;
      end else if (ack_enter) begin
         ack_q <= 1'b1;
         if ((state_q == ism_pkg::DEV_ADDR) & ~dev_hit) begin
            state_q <= ism_pkg::DEV_IDLE;
            ack_q <= 1'b0;
         end else if ((state_q == ism_pkg::DEV_WR) & wp_s_q) begin
            state_q <= ism_pkg::DEV_IDLE;
            ack_q <= 1'b0;
         end
      end else if (ack_leave) begin
         ack_q <= 1'b0;
         cnt_q <= load_rd ? 4'h1 : 4'h0;
         unique case (state_q)
            ism_pkg::DEV_ADDR: begin
               state_q <= dir_rd_q ? ism_pkg::DEV_RD : ism_pkg::DEV_WORD;
            end
            ism_pkg::DEV_WORD: begin
               state_q <= ism_pkg::DEV_WR;
            end
            ism_pkg::DEV_WR: begin
               state_q <= ism_pkg::DEV_WR;
            end
            ism_pkg::DEV_RD: begin
               // a released line in the acknowledge bit ends the read
               state_q <= mack_q ? ism_pkg::DEV_RD : ism_pkg::DEV_IDLE;
            end
            ism_pkg::DEV_IDLE: begin
               state_q <= ism_pkg::DEV_IDLE;
            end
         endcase
      end
   end

   // shift register: bits in on rising edges, bits out on falling edges
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sh_q <= 8'h00;
      end else if (scl_rise & ~ack_q & rx_state) begin
         sh_q <= byte_in;
      end else if (load_rd) begin
         sh_q <= {rd_byte[6:0], 1'b0};
      end else if (tx_bit) begin
         sh_q <= {sh_q[6:0], 1'b0};
      end
   end

   // direction flag and master acknowledge during reads
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dir_rd_q <= 1'b0;
         mack_q <= 1'b0;
      end else begin
         if (ack_enter & (state_q == ism_pkg::DEV_ADDR)) begin
            dir_rd_q <= sh_q[0];
         end
         if (scl_rise & ack_q & (state_q == ism_pkg::DEV_RD)) begin
            mack_q <= ~sda_s_q;
         end
      end
   end

   // address latch: page from the address byte, low bits from the word byte
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         addr_q <= '0;
      end else if (ack_enter & (state_q == ism_pkg::DEV_ADDR) & dev_hit) begin
         addr_q[ADDR_W-1:8] <= sh_q[`ISM_PAGE_LSB +: PG_W];
      end else if (ack_enter & (state_q == ism_pkg::DEV_WORD)) begin
         addr_q[7:0] <= sh_q;
      end else if (wr_commit | (ack_enter & (state_q == ism_pkg::DEV_RD))) begin
         addr_q <= addr_q + 1'b1;
      end
   end

   // the array takes the byte as its eighth bit arrives, no busy time
   always_ff @(posedge mclk) begin
      if (wr_commit) begin
         mem[addr_q] <= byte_in;
      end
   end

   // open-drain data output: enable high pulls the line low
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sda_oe_q <= 1'b0;
      end else if (start_ev | stop_ev) begin
         sda_oe_q <= 1'b0;
      end else if (ack_enter) begin
         unique case (state_q)
            ism_pkg::DEV_ADDR: sda_oe_q <= dev_hit;
            ism_pkg::DEV_WORD: sda_oe_q <= 1'b1;
            ism_pkg::DEV_WR: sda_oe_q <= ~wp_s_q;
            ism_pkg::DEV_RD: sda_oe_q <= 1'b0;
            ism_pkg::DEV_IDLE: sda_oe_q <= 1'b0;
         endcase
      end else if (load_rd) begin
         sda_oe_q <= ~rd_byte[7];
      end else if (ack_leave) begin
         sda_oe_q <= 1'b0;
      end else if (tx_bit) begin
         sda_oe_q <= ~sh_q[7];
      end
   end

   // user-side view of the block
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         selected_q <= 1'b0;
         wr_pulse_q <= 1'b0;
         wr_data_q <= 8'h00;
      end else begin
         selected_q <= state_q != ism_pkg::DEV_IDLE;
         wr_pulse_q <= wr_commit;
         if (wr_commit) begin
            wr_data_q <= byte_in;
         end
      end
   end

   assign bus.s_sda_o = 1'b0;
   assign bus.s_sda_oe = sda_oe_q;
   assign selected = selected_q;
   assign cur_addr = addr_q;
   assign wr_pulse = wr_pulse_q;
   assign wr_data = wr_data_q;
endmodule

// [logic/ism_master.sv]
// two-wire bus master: byte-level commands from a small register port
`timescale 1ns/1ps
`include "ism_consts.svh"
module ism_master (
   input wire logic mclk,
   input wire logic resetn,
   ism_if.master bus,
   input wire ism_pkg::ism_addr_t addr,
   input wire ism_pkg::ism_word_t wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output ism_pkg::ism_word_t rdata
);
   ism_pkg::ism_mst_state_e state_q;
   ism_pkg::ism_word_t div_q;
   ism_pkg::ism_word_t cnt_q;
   ism_pkg::ism_word_t rdata_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic rd_q;
   logic ackm_q;
   logic [7:0] sh_q;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic nak_q;
   logic scl_oe_q;
   logic sda_oe_q;
   logic sda_m_q;
   logic sda_s_q;
   logic tick;
   logic launch;
   logic last_bit;
   ism_pkg::ism_cmd_e cmd;

   assign cmd = ism_pkg::ism_cmd_e'(wdata[1:0]);
   assign launch = wr_en & (addr == `ISM_OFS_CMD) & (state_q == ism_pkg::MS_IDLE);
   assign tick = (state_q != ism_pkg::MS_IDLE) & (cnt_q == div_q - 16'h0001);
   assign last_bit = bit_q == 4'h8;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         sda_m_q <= bus.sda;
         sda_s_q <= sda_m_q;
      end
   end

   // quarter-bit divider
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 16'h0000;
      end else if (state_q == ism_pkg::MS_IDLE || tick) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         div_q <= 16'(`ISM_QTR_CYC);
         tx_q <= 8'h00;
      end else if (wr_en) begin
         if (addr == `ISM_OFS_DIV && wdata >= `ISM_QTR_MIN) begin
            div_q <= wdata;
         end
         if (addr == `ISM_OFS_TX) begin
            tx_q <= wdata[7:0];
         end
      end
   end

   // command sequencer: four quarters per bit, clock low in quarters 0 and 1
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ism_pkg::MS_IDLE;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         rd_q <= 1'b0;
         ackm_q <= 1'b0;
         sh_q <= 8'h00;
      end else if (launch) begin
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         rd_q <= cmd == ism_pkg::CMD_READ;
         ackm_q <= wdata[`ISM_CMD_ACK_BIT];
         sh_q <= tx_q;
         unique case (cmd)
            ism_pkg::CMD_START: state_q <= ism_pkg::MS_START;
            ism_pkg::CMD_WRITE: state_q <= ism_pkg::MS_BYTE;
            ism_pkg::CMD_READ: state_q <= ism_pkg::MS_BYTE;
            ism_pkg::CMD_STOP: state_q <= ism_pkg::MS_STOP;
         endcase
      end else if (tick) begin
         ph_q <= ph_q + 2'h1;
         if (state_q == ism_pkg::MS_BYTE && ph_q == 2'h2 && rd_q && !last_bit) begin
            sh_q <= {sh_q[6:0], sda_s_q};
         end
         if (ph_q == 2'h3) begin
            if (state_q != ism_pkg::MS_BYTE || last_bit) begin
               state_q <= ism_pkg::MS_IDLE;
            end
            bit_q <= bit_q + 4'h1;
            if (!rd_q) begin
               sh_q <= {sh_q[6:0], 1'b0};
            end
         end
      end
   end

   // line drivers: changes only while the clock is low, except conditions
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (tick) begin
         unique case (ph_q)
            2'h0: begin
               if (state_q == ism_pkg::MS_START) begin
                  scl_oe_q <= 1'b1;
                  sda_oe_q <= 1'b0;
               end else if (state_q == ism_pkg::MS_STOP) begin
                  sda_oe_q <= 1'b1;
               end else if (last_bit) begin
                  sda_oe_q <= rd_q & ackm_q;
               end else begin
                  sda_oe_q <= ~rd_q & ~sh_q[7];
               end
            end
            2'h1: scl_oe_q <= 1'b0;
            2'h2: begin
               if (state_q == ism_pkg::MS_START) begin
                  sda_oe_q <= 1'b1;
               end else if (state_q == ism_pkg::MS_STOP) begin
                  sda_oe_q <= 1'b0;
               end
            end
            2'h3: scl_oe_q <= state_q != ism_pkg::MS_STOP;
         endcase
      end
   end

   // byte results; a new no-acknowledge wins over a clear
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rx_q <= 8'h00;
         nak_q <= 1'b0;
      end else begin
         if (tick && state_q == ism_pkg::MS_BYTE && ph_q == 2'h2 && last_bit) begin
            if (rd_q) begin
               rx_q <= sh_q;
            end else begin
               nak_q <= sda_s_q;
            end
         end else if (wr_en && addr == `ISM_OFS_STAT && wdata[`ISM_STAT_NAK_BIT]) begin
            nak_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 16'h0000;
      end else if (rd_en) begin
         unique case (addr)
            `ISM_OFS_TX: rdata_q <= {8'h00, tx_q};
            `ISM_OFS_RX: rdata_q <= {8'h00, rx_q};
            `ISM_OFS_STAT: rdata_q <= {13'h0000, sda_s_q, nak_q, state_q != ism_pkg::MS_IDLE};
            `ISM_OFS_DIV: rdata_q <= div_q;
            default: rdata_q <= 16'h0000;
         endcase
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign bus.m_scl_o = 1'b0;
   assign bus.m_scl_oe = scl_oe_q;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_sda_oe = sda_oe_q;
   assign rdata = rdata_q;
endmodule

// [sim/ism_link_sva.sv]
// bus-level checks on the two-wire link between master and slave
`timescale 1ns/1ps
module ism_link_sva (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic m_scl_o,
   input wire logic m_scl_oe,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   logic scl_q;
   logic sda_q;
   logic idle_q;
   logic cond_q;
   logic [7:0] rise_q;
   logic [7:0] low_q;
   logic start_det;
   logic stop_det;
   assign start_det = scl && scl_q && sda_q && !sda;
   assign stop_det = scl && scl_q && !sda_q && sda;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   // bus free from stop to start; a condition was seen in this high phase
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         idle_q <= 1'b1;
         cond_q <= 1'b0;
      end else begin
         if (start_det)
            idle_q <= 1'b0;
         else if (stop_det)
            idle_q <= 1'b1;
         if (start_det || stop_det)
            cond_q <= 1'b1;
         else if (!scl)
            cond_q <= 1'b0;
      end
   end
   // clock rises since start, cycles since the clock went low
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rise_q <= 8'h00;
         low_q <= 8'h00;
      end else begin
         if (start_det)
            rise_q <= 8'h00;
         else if (scl && !scl_q && rise_q != 8'hFF)
            rise_q <= rise_q + 8'h01;
         if (scl)
            low_q <= 8'h00;
         else if (low_q != 8'hFF)
            low_q <= low_q + 8'h01;
      end
   end
   AST_BUS_FREE_QUIET: assert property (idle_q |-> !s_sda_oe)
      else $error("slave pulls data while the bus is free");
   AST_ADDR_BYTE_FIRST: assert property ($rose(s_sda_oe) |-> rise_q >= 8'h08)
      else $error("slave pulls data before eight clocks of a byte");
   AST_CHANGE_AFTER_FALL: assert property ($changed(s_sda_oe) |->
      !scl && low_q >= 8'h02 && low_q <= 8'h06)
      else $error("slave data changed outside the low phase window");
   AST_STABLE_WHILE_HIGH: assert property (scl && scl_q && !cond_q |-> $stable(s_sda_oe))
      else $error("slave data changed while the clock is high");
   AST_ONE_PULLER_HIGH: assert property (scl |-> !(m_sda_oe && s_sda_oe))
      else $error("both ends pull data during a high phase");
   AST_ACK_HOLDS_HIGH: assert property ($rose(scl) && s_sda_oe |-> s_sda_oe [*4])
      else $error("slave released data early in a high phase");
   AST_HIGH_PHASE_MIN: assert property ($rose(scl) |=> scl [*3])
      else $error("clock high phase too short");
   AST_START_NO_ECHO: assert property (start_det |=> !s_sda_oe [*8])
      else $error("slave pulls data right after a start");
   AST_PULL_GIVES_LOW: assert property (m_sda_oe || s_sda_oe |-> !sda)
      else $error("a pulled data line does not read low");
   AST_OPEN_DRAIN_ONLY: assert property (!(m_scl_o || m_sda_o || s_sda_o))
      else $error("a line driver would drive high");
   cover property (start_det);
   cover property (stop_det);
   cover property (scl && s_sda_oe && rise_q > 8'h09);
endmodule

// [sim/ism_bench.sv]
// self-checking bench: master and serial memory slave joined by the link
`timescale 1ns/1ps
`include "ism_consts.svh"
module ism_bench;
   logic mclk;
   logic resetn;
   logic wp;
   ism_pkg::ism_addr_t addr;
   ism_pkg::ism_word_t wdata;
   logic wr_en;
   logic rd_en;
   ism_pkg::ism_word_t rdata;
   logic selected;
   logic [10:0] cur_addr;
   logic wr_pulse;
   logic [7:0] wr_data;
   int error_cnt = 0;
   int checks_done = 0;
   int wr_cnt = 0;
   int mem [0:2047];
   int lat = 0;
   logic [31:0] lfsr_q = 32'h00015726;
   ism_if bus_if ();
   ism_master ism_master_inst (.mclk(mclk), .resetn(resetn), .bus(bus_if.master), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
   ism_dev ism_dev_inst (.mclk(mclk), .resetn(resetn), .bus(bus_if.dev), .wp(wp),
      .selected(selected), .cur_addr(cur_addr), .wr_pulse(wr_pulse), .wr_data(wr_data));
   ism_link_sva ism_link_sva_inst (.mclk(mclk), .resetn(resetn), .m_scl_o(bus_if.m_scl_o),
      .m_scl_oe(bus_if.m_scl_oe), .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe),
      .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
   always @(posedge mclk) begin
      if (wr_pulse === 1'b1)
         wr_cnt <= wr_cnt + 1;
   end
   task automatic stop_test();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input int exp);
      checks_done++;
      if (got !== 16'(exp)) begin
         error_cnt++;
         $display("Error at %0t: got %h, expected %h", $time, got, 16'(exp));
      end
   endtask
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q[7:0];
   endfunction
   task automatic reg_wr(input ism_pkg::ism_addr_t a, input ism_pkg::ism_word_t d);
      @(posedge mclk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   task automatic reg_rd(input ism_pkg::ism_addr_t a, output ism_pkg::ism_word_t d);
      @(posedge mclk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask
   // issue one command and poll until the master is no longer busy
   task automatic run(input ism_pkg::ism_word_t c);
      ism_pkg::ism_word_t s;
      reg_wr(`ISM_OFS_CMD, c);
      repeat (2) @(posedge mclk);
      for (int i = 0; i < 400; i++) begin
         reg_rd(`ISM_OFS_STAT, s);
         if (s[0] === 1'b0)
            break;
      end
      chk(16'(s[0]), 0);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic nak);
      ism_pkg::ism_word_t s;
      reg_wr(`ISM_OFS_TX, {8'h00, b});
      run(16'h0001);
      reg_rd(`ISM_OFS_STAT, s);
      nak = s[1];
      if (s[1] === 1'b1)
         reg_wr(`ISM_OFS_STAT, 16'h0002);
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] b);
      ism_pkg::ism_word_t s;
      run(ack ? 16'h0006 : 16'h0002);
      reg_rd(`ISM_OFS_RX, s);
      b = s[7:0];
   endtask
   task automatic wr_seq(input logic [2:0] p, input logic [7:0] w, input int n, input logic prot);
      logic nak;
      logic [7:0] d;
      int wc;
      run(16'h0000);
      wbyte({`ISM_DEV_TYPE_DFLT, p, 1'b0}, nak);
      chk(16'(nak), 0);
      wbyte(w, nak);
      lat = int'({p, w});
      chk(16'(nak), 0);
      chk(16'(cur_addr), lat);
      chk(16'(selected), 1);
      for (int i = 0; i < n; i++) begin
         d = rnd();
         wc = wr_cnt;
         wbyte(d, nak);
         chk(16'(nak), int'(prot));
         chk(16'(wr_cnt - wc), int'(!prot));
         if (!prot) begin
            mem[lat] = int'(d);
            chk(16'(wr_data), int'(d));
            lat = (lat + 1) % 2048;
         end
         chk(16'(cur_addr), lat);
      end
      run(16'h0003);
      chk(16'(selected), 0);
   endtask
   task automatic rd_seq(input logic [2:0] p, input int n, input logic rnd_adr,
      input logic [7:0] w);
      logic nak;
      logic [7:0] d;
      run(16'h0000);
      if (rnd_adr) begin
         wbyte({`ISM_DEV_TYPE_DFLT, p, 1'b0}, nak);
         wbyte(w, nak);
         lat = int'({p, w});
         run(16'h0000);
      end
      wbyte({`ISM_DEV_TYPE_DFLT, p, 1'b1}, nak);
      chk(16'(nak), 0);
      lat = int'(p) * 256 + lat % 256;
      chk(16'(cur_addr), lat);
      for (int i = 0; i < n; i++) begin
         rbyte(i != n - 1, d);
         chk(16'(d), mem[lat]);
         lat = (lat + 1) % 2048;
         chk(16'(cur_addr), lat);
      end
      run(16'h0003);
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      repeat (90000) @(posedge mclk);
      error_cnt++;
      stop_test();
   end
   initial begin
      ism_pkg::ism_word_t s;
      logic [7:0] w;
      logic nak;
      resetn = 1'b0;
      wp = 1'b0;
      addr = 5'h00;
      wdata = 16'h0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      #1;
      chk(16'(cur_addr), 0);
      chk(16'(selected), 0);
      reg_rd(`ISM_OFS_STAT, s);
      chk(s, 4);
      reg_wr(`ISM_OFS_DIV, 16'h0008);
      run(16'h0000);
      wbyte({`ISM_DEV_TYPE_DFLT ^ 4'h3, 4'h0}, nak);
      chk(16'(nak), 1);
      run(16'h0003);
      for (int p = 0; p < 8; p++) begin
         w = rnd();
         wr_seq(3'(p), w, 3, 1'b0);
         rd_seq(3'(p), 3, 1'b1, w);
      end
      wr_seq(3'h7, 8'hFE, 5, 1'b0);
      rd_seq(3'h7, 3, 1'b1, 8'hFE);
      rd_seq(3'h0, 2, 1'b0, 8'h00);
      @(posedge mclk);
      wp <= 1'b1;
      repeat (4) @(posedge mclk);
      wr_seq(3'h7, 8'hFE, 1, 1'b1);
      @(posedge mclk);
      wp <= 1'b0;
      repeat (4) @(posedge mclk);
      rd_seq(3'h7, 1, 1'b1, 8'hFE);
      stop_test();
   end
endmodule
